//--- design/ers_rx_status_bank.sv
`include "ers_params.svh"

module ers_rx_status_bank #(
  parameter int MS_CYCLES = `ERS_MS_CYCLES,
  parameter logic [7:0] DEVICE_ID = 8'h5c // Arbitrary identity value
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_cs_n,
  input wire logic i_rd_n,
  input wire logic [7:0] i_page,
  input wire logic [4:0] i_addr,
  input wire ers_pkg::ers_rx_status_t i_rx,
  input wire ers_pkg::ers_aux_regs_t i_aux,
  output logic [7:0] o_data,
  output logic o_data_oe_n,
  output logic o_force_reframe
);
  import ers_pkg::*;

  // ------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------
  logic cs_n_meta_ff, cs_n_ff, rd_n_meta_ff, rd_n_ff;
  logic [7:0] page_meta_ff, page_ff;
  logic [4:0] addr_meta_ff, addr_ff;

  // Only the second stage feeds the decode
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cs_n_meta_ff <= 1'b1;
      cs_n_ff <= 1'b1;
      rd_n_meta_ff <= 1'b1;
      rd_n_ff <= 1'b1;
      page_meta_ff <= 8'h00;
      page_ff <= 8'h00;
      addr_meta_ff <= 5'h00;
      addr_ff <= 5'h00;
    end else begin
      cs_n_meta_ff <= i_cs_n;
      cs_n_ff <= cs_n_meta_ff;
      rd_n_meta_ff <= i_rd_n;
      rd_n_ff <= rd_n_meta_ff;
      page_meta_ff <= i_page;
      page_ff <= page_meta_ff;
      addr_meta_ff <= i_addr;
      addr_ff <= addr_meta_ff;
    end
  end

  // ------------------------------------------------
  // Millisecond base
  // ------------------------------------------------
  logic [15:0] ms_cnt_ff;
  logic ms_tick;
  logic ms_toggle_ff;
  logic crc_realign;

  // Restart the ms grid on the CRC-4 sync once aligned
  assign crc_realign = i_rx.crc4_sync & ~i_rx.crc4_mf_loss;
  // Tick on the last cycle of each millisecond
  assign ms_tick = (ms_cnt_ff == 16'(MS_CYCLES - 1));

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ms_cnt_ff <= 16'h0000;
    end else if (ms_tick || crc_realign) begin
      ms_cnt_ff <= 16'h0000;
    end else begin
      ms_cnt_ff <= ms_cnt_ff + 16'h0001;
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ms_toggle_ff <= 1'b0;
    end else if (ms_tick || crc_realign) begin
      ms_toggle_ff <= ~ms_toggle_ff;
    end
  end

  // ------------------------------------------------
  // Half and one second toggles
  // ------------------------------------------------
  logic [8:0] half_cnt_ff;
  logic half_toggle_ff, sec_toggle_ff;
  logic half_tick;

  assign half_tick = ms_tick && (half_cnt_ff == 9'(`ERS_HALF_SEC_MS - 1));

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      half_cnt_ff <= 9'h000;
    end else if (half_tick) begin
      half_cnt_ff <= 9'h000;
    end else if (ms_tick) begin
      half_cnt_ff <= half_cnt_ff + 9'h001;
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      half_toggle_ff <= 1'b0;
      sec_toggle_ff <= 1'b0;
    end else if (half_tick) begin
      half_toggle_ff <= ~half_toggle_ff;
      if (half_toggle_ff) begin
        sec_toggle_ff <= ~sec_toggle_ff;
      end
    end
  end

  // ------------------------------------------------
  // Persistence timers
  // ------------------------------------------------
  logic [6:0] red_cnt_ff, nn_cnt_ff, norm_cnt_ff, klv_cnt_ff;
  logic red_ff, nn_ff, norm_ff, klv_ff;
  // Each count stops once its flag is up

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      red_cnt_ff <= 7'h00;
      red_ff <= 1'b0;
    end else if (!i_rx.frame_loss) begin
      red_cnt_ff <= 7'h00;
      red_ff <= 1'b0;
    end else if (ms_tick && !red_ff) begin
      red_cnt_ff <= red_cnt_ff + 7'h01;
      red_ff <= (red_cnt_ff == 7'(`ERS_RED_MS - 1));
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      nn_cnt_ff <= 7'h00;
      nn_ff <= 1'b0;
    end else if (norm_ff) begin
      nn_cnt_ff <= 7'h00;
      nn_ff <= 1'b0;
    end else if (!i_rx.nonnormal_frames) begin
      nn_cnt_ff <= 7'h00;
    end else if (ms_tick && !nn_ff) begin
      nn_cnt_ff <= nn_cnt_ff + 7'h01;
      nn_ff <= (nn_cnt_ff == 7'(`ERS_NONNORMAL_MS - 1));
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      norm_cnt_ff <= 7'h00;
      norm_ff <= 1'b0;
    end else if (i_rx.nonnormal_frames) begin
      norm_cnt_ff <= 7'h00;
      norm_ff <= 1'b0;
    end else if (!i_rx.terminal_sync) begin
      norm_cnt_ff <= 7'h00;
    end else if (ms_tick && !norm_ff) begin
      norm_cnt_ff <= norm_cnt_ff + 7'h01;
      norm_ff <= (norm_cnt_ff == 7'(`ERS_NORMAL_MS - 1));
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      klv_cnt_ff <= 7'h00;
      klv_ff <= 1'b0;
    end else if (!i_rx.ais) begin
      klv_cnt_ff <= 7'h00;
      klv_ff <= 1'b0;
    end else if (ms_tick && !klv_ff) begin
      klv_cnt_ff <= klv_cnt_ff + 7'h01;
      klv_ff <= (klv_cnt_ff == 7'(`ERS_KEEPALIVE_MS - 1));
    end
  end

  // ------------------------------------------------
  // CRC-4 alignment hunt after basic framing
  // ------------------------------------------------
  ers_crc_state_t crc_state_ff;
  logic [8:0] hunt_cnt_ff;
  logic short_exp, long_exp;
  logic short_tgl_ff, long_tgl_ff, reframe_ff, iwk_ff, force_ff;

  // Both expiries count ticks spent in the hunt
  assign short_exp = (crc_state_ff == ERS_HUNT) && ms_tick &&
                     (hunt_cnt_ff == 9'(`ERS_SHORT_MS - 1));
  assign long_exp = (crc_state_ff == ERS_HUNT) && ms_tick &&
                    (hunt_cnt_ff == 9'(`ERS_LONG_MS - 1));

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      crc_state_ff <= ERS_IDLE;
    end else if (i_rx.frame_loss) begin
      crc_state_ff <= ERS_IDLE;
    end else begin
      case (crc_state_ff)
        ERS_IDLE: crc_state_ff <= ERS_HUNT;
        ERS_HUNT: begin
          if (!i_rx.crc4_mf_loss || long_exp) begin
            crc_state_ff <= ERS_DONE;
          end
        end
        default: crc_state_ff <= ERS_DONE;
      endcase
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      hunt_cnt_ff <= 9'h000;
    end else if (crc_state_ff != ERS_HUNT) begin
      hunt_cnt_ff <= 9'h000;
    end else if (ms_tick) begin
      hunt_cnt_ff <= hunt_cnt_ff + 9'h001;
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      short_tgl_ff <= 1'b0;
      long_tgl_ff <= 1'b0;
    end else begin
      if (short_exp) begin
        short_tgl_ff <= ~short_tgl_ff;
      end
      if (long_exp) begin
        long_tgl_ff <= ~long_tgl_ff;
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      reframe_ff <= 1'b0;
      force_ff <= 1'b0;
    end else begin
      force_ff <= short_exp && i_rx.crc4_mf_loss && i_rx.maintenance_mode &&
                  !i_rx.auto_interworking;
      // Set wins over both clears
      if (short_exp && i_rx.crc4_mf_loss) begin
        reframe_ff <= 1'b1;
      end else if (crc_state_ff == ERS_IDLE || !i_rx.crc4_mf_loss) begin
        reframe_ff <= 1'b0;
      end
    end
  end

  // Acquisition wins over expiry
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      iwk_ff <= 1'b0;
    end else if (!i_rx.crc4_mf_loss && !i_rx.frame_loss) begin
      iwk_ff <= 1'b1;
    end else if (long_exp) begin
      iwk_ff <= 1'b0;
    end
  end

  // ------------------------------------------------
  // Captured line bits
  // ------------------------------------------------
  logic ebit_one_ff, ebit_two_ff;
  logic [7:0] fas_ff;

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ebit_one_ff <= 1'b0;
      ebit_two_ff <= 1'b0;
    end else if (i_rx.ebit_valid) begin
      ebit_one_ff <= i_rx.far_ebit_one;
      ebit_two_ff <= i_rx.far_ebit_two;
    end
  end

  // Bit 7 holds the first bit of the signal
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      fas_ff <= `ERS_FAS_RST;
    end else if (i_rx.fas_valid) begin
      fas_ff <= i_rx.fas_byte;
    end
  end

  // ------------------------------------------------
  // Register views
  // ------------------------------------------------
  logic [7:0] sync_status, timer_status;

  always_comb begin
    sync_status = 8'h00;
    sync_status[`ERS_SS_FRAME_LOSS] = i_rx.frame_loss;
    sync_status[`ERS_SS_SIG_MF_LOSS] = i_rx.signalling_mf_loss;
    sync_status[`ERS_SS_CRC4_MF_LOSS] = i_rx.crc4_mf_loss;
    sync_status[`ERS_SS_EBIT_ONE] = ebit_one_ff;
    sync_status[`ERS_SS_EBIT_TWO] = ebit_two_ff;
    sync_status[`ERS_SS_REFRAME] = reframe_ff;
    sync_status[`ERS_SS_RED] = red_ff;
    sync_status[`ERS_SS_IWK] = iwk_ff;
  end

  always_comb begin
    timer_status = 8'h00;
    timer_status[`ERS_TS_HALF_SEC] = half_toggle_ff;
    timer_status[`ERS_TS_ONE_SEC] = sec_toggle_ff;
    timer_status[`ERS_TS_NONNORMAL] = nn_ff;
    timer_status[`ERS_TS_NORMAL] = norm_ff;
    timer_status[`ERS_TS_LONG] = long_tgl_ff;
    timer_status[`ERS_TS_SHORT] = short_tgl_ff;
    timer_status[`ERS_TS_MS] = ms_toggle_ff;
    timer_status[`ERS_TS_KEEPALIVE] = klv_ff;
  end

  // ------------------------------------------------
  // Read port, writes ignored
  // ------------------------------------------------
  logic [7:0] nxt_data;
  logic rd_sel;

  assign rd_sel = !cs_n_ff && !rd_n_ff && (page_ff == `ERS_PAGE);

  // Offsets outside the bank read as zero
  always_comb begin
    if (addr_ff == `ERS_SYNC_STATUS) begin
      nxt_data = sync_status;
    end else if (addr_ff == `ERS_RX_FAS) begin
      nxt_data = fas_ff;
    end else if (addr_ff == `ERS_TIMER_STATUS) begin
      nxt_data = timer_status;
    end else if (addr_ff == `ERS_RX_NFAS) begin
      nxt_data = i_aux.nfas;
    end else if (addr_ff == `ERS_RX_MFAS) begin
      nxt_data = i_aux.mfas;
    end else if (addr_ff == `ERS_PHASE_HIGH) begin
      nxt_data = i_aux.phase_high;
    end else if (addr_ff == `ERS_PHASE_LOW) begin
      nxt_data = i_aux.phase_low;
    end else if (addr_ff == `ERS_JITTER) begin
      nxt_data = i_aux.jitter;
    end else if (addr_ff == `ERS_RX_LEVEL) begin
      nxt_data = i_aux.level;
    end else if (addr_ff == `ERS_ALARM_ONE) begin
      nxt_data = i_aux.alarm_one;
    end else if (addr_ff == `ERS_SA6_REPORT) begin
      nxt_data = i_aux.sa6_report;
    end else if (addr_ff == `ERS_DEVICE_ID) begin
      nxt_data = DEVICE_ID; // Value arbitrary
    end else begin
      nxt_data = 8'h00;
    end
  end

  // Reading changes nothing but the data pins
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_data <= 8'h00;
      o_data_oe_n <= 1'b1;
    end else begin
      o_data <= rd_sel ? nxt_data : 8'h00;
      o_data_oe_n <= !rd_sel;
    end
  end

  // ------------------------------------------------
  // Reframe request
  // ------------------------------------------------
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_force_reframe <= 1'b0;
    end else begin
      o_force_reframe <= force_ff;
    end
  end
endmodule : ers_rx_status_bank

//--- design/ers_params.svh
`ifndef ERS_PARAMS_SVH
`define ERS_PARAMS_SVH
// Notes on behaviour
// - Bit 7 of sync status: frame loss
// - Bit 6: signalling multiframe loss
// - Bit 5: CRC-4 multiframe loss
// - Bits 4,3 hold last multiframe E-bits
// - Reframe flag if no CRC-4 in 8 ms
// - Frame-loss alarm after 100 ms loss
// - Bit 0 shows CRC-4 interworking result
// - Capture first FAS bit into bit 7
// - Capture FAS bits two-eight into 6-0
// - Timer bit 7 toggles every half second
// - Timer bit 6 toggles every second
// - Non-normal frame timer: 100 ms persistence
// - Normal frame timer: 10 ms persistence
// - Toggle bit 3 on 400 ms expiry
// - Toggle bit 2 on 8 ms expiry
// - Bit 1 toggles each ms, CRC-synced
// - Keep-alive after AIS high 100 ms
// - Bank at 10H-1AH and 1FH, page 03H

// ------------------------------------------------
// Register offsets
// ------------------------------------------------
`define ERS_PAGE 8'h03
`define ERS_SYNC_STATUS 5'h10
`define ERS_RX_FAS 5'h11
`define ERS_TIMER_STATUS 5'h12
`define ERS_RX_NFAS 5'h13
`define ERS_RX_MFAS 5'h14
`define ERS_PHASE_HIGH 5'h15
`define ERS_PHASE_LOW 5'h16
`define ERS_JITTER 5'h17
`define ERS_RX_LEVEL 5'h18
`define ERS_ALARM_ONE 5'h19
`define ERS_SA6_REPORT 5'h1a
`define ERS_DEVICE_ID 5'h1f

// ------------------------------------------------
// Field positions
// ------------------------------------------------
`define ERS_SS_FRAME_LOSS 7
`define ERS_SS_SIG_MF_LOSS 6
`define ERS_SS_CRC4_MF_LOSS 5
`define ERS_SS_EBIT_ONE 4
`define ERS_SS_EBIT_TWO 3
`define ERS_SS_REFRAME 2
`define ERS_SS_RED 1
`define ERS_SS_IWK 0
`define ERS_TS_HALF_SEC 7
`define ERS_TS_ONE_SEC 6
`define ERS_TS_NONNORMAL 5
`define ERS_TS_NORMAL 4
`define ERS_TS_LONG 3
`define ERS_TS_SHORT 2
`define ERS_TS_MS 1
`define ERS_TS_KEEPALIVE 0

// ------------------------------------------------
// Reset values
// ------------------------------------------------
`define ERS_FAS_RST 8'h00
`define ERS_LOSS_RST 1'b1

// ------------------------------------------------
// Timing
// ------------------------------------------------
`define ERS_CLK_HZ 10000000
`define ERS_MS_CYCLES (`ERS_CLK_HZ / 1000)
`define ERS_HALF_SEC_MS 500
`define ERS_RED_MS 100
`define ERS_NONNORMAL_MS 100
`define ERS_NORMAL_MS 10
`define ERS_LONG_MS 400
`define ERS_SHORT_MS 8
`define ERS_KEEPALIVE_MS 100
`endif

//--- design/ers_pkg.sv
package ers_pkg;
  // Framer state feeding the bank
  typedef struct packed {
    logic frame_loss;
    logic signalling_mf_loss;
    logic crc4_mf_loss;
    logic ebit_valid;
    logic far_ebit_one;
    logic far_ebit_two;
    logic fas_valid;
    logic [7:0] fas_byte;
    logic nonnormal_frames;
    logic terminal_sync;
    logic ais;
    logic crc4_sync;
    logic maintenance_mode;
    logic auto_interworking;
  } ers_rx_status_t;

  // Bytes owned by neighbouring receive blocks
  typedef struct packed {
    logic [7:0] nfas;
    logic [7:0] mfas;
    logic [7:0] phase_high;
    logic [7:0] phase_low;
    logic [7:0] jitter;
    logic [7:0] level;
    logic [7:0] alarm_one;
    logic [7:0] sa6_report;
  } ers_aux_regs_t;

  typedef enum logic [2:0] {
    ERS_IDLE = 3'b001,
    ERS_HUNT = 3'b010,
    ERS_DONE = 3'b100
  } ers_crc_state_t;
endpackage : ers_pkg

//--- dv/ers_rx_status_bank_chk.sv
module ers_rx_status_bank_chk
  import ers_pkg::*;
#(
  parameter int MS_CYCLES = 10,
  parameter logic [7:0] DEVICE_ID = 8'h00
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_cs_n,
  input wire logic i_rd_n,
  input wire logic [7:0] i_page,
  input wire logic [4:0] i_addr,
  input wire ers_pkg::ers_rx_status_t i_rx,
  input wire ers_pkg::ers_aux_regs_t i_aux,
  input wire logic [7:0] o_data,
  input wire logic o_data_oe_n,
  input wire logic o_force_reframe
);
  timeunit 1ns;
  timeprecision 1ns;
  logic rd_ok;
  logic [7:0] last_fas_ff;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  assign rd_ok = !i_cs_n && !i_rd_n && i_page == 8'h03;

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      last_fas_ff <= 8'h00;
    end else if (i_rx.fas_valid) begin
      last_fas_ff <= i_rx.fas_byte;
    end
  end

  AST_IDLE_QUIET: assert property (i_cs_n [*3] |=> o_data_oe_n && o_data == 8'h00)
    else $error("bus driven without select");
  AST_PAGE_FILTER: assert property ((i_page != 8'h03) [*3] |=> o_data_oe_n)
    else $error("bus driven on other page");
  AST_BANK_DRIVES: assert property ((rd_ok && i_addr[4]) [*3] |=> !o_data_oe_n)
    else $error("bank read not answered");
  AST_UNUSED_ZERO: assert property ((rd_ok && i_addr inside {[5'h1b:5'h1e]}) [*3] |=> o_data == 8'h00)
    else $error("unused offset not zero");
  AST_DEVICE_ID: assert property ((rd_ok && i_addr == 5'h1f) [*3] |=> o_data == DEVICE_ID)
    else $error("identity word wrong");
  AST_FAS_CAPTURE: assert property ((rd_ok && i_addr == 5'h11 && !i_rx.fas_valid) [*4] |-> o_data == last_fas_ff)
    else $error("alignment byte wrong");
  AST_SYNC_LEVELS: assert property ((rd_ok && i_addr == 5'h10) [*4]
    |-> o_data[7:5] == {$past(i_rx.frame_loss), $past(i_rx.signalling_mf_loss), $past(i_rx.crc4_mf_loss)})
    else $error("loss bits wrong");
  AST_REFRAME_PULSE: assert property (o_force_reframe |-> $past(i_rx.maintenance_mode, 2) &&
    !$past(i_rx.auto_interworking, 2) ##1 !o_force_reframe)
    else $error("reframe pulse wrong");

  COV_REFRAME: cover property (o_force_reframe);
  COV_ID_READ: cover property ((rd_ok && i_addr == 5'h1f) [*4]);
  COV_FAS_READ: cover property ((rd_ok && i_addr == 5'h11) [*4]);
endmodule : ers_rx_status_bank_chk

bind ers_rx_status_bank ers_rx_status_bank_chk #(.MS_CYCLES(MS_CYCLES), .DEVICE_ID(DEVICE_ID)) u_chk (
  .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_cs_n(i_cs_n), .i_rd_n(i_rd_n), .i_page(i_page),
  .i_addr(i_addr), .i_rx(i_rx), .i_aux(i_aux), .o_data(o_data), .o_data_oe_n(o_data_oe_n),
  .o_force_reframe(o_force_reframe));

//--- dv/ers_far_end.sv
module ers_far_end
  import ers_pkg::*;
(
  input wire logic i_clk,
  output ers_pkg::ers_rx_status_t o_rx
);
  timeunit 1ns;
  timeprecision 1ns;
  ers_rx_status_t rx = '0;

  assign o_rx = rx;

  // Kind 0 alignment byte, 1 E-bits, 2 CRC-4 sync; data goes stale after
  task automatic pulse(input int k, input logic [7:0] b);
    @(posedge i_clk);
    #1;
    rx.fas_byte = b;
    {rx.far_ebit_one, rx.far_ebit_two} = b[1:0];
    {rx.crc4_sync, rx.ebit_valid, rx.fas_valid} = 3'b001 << k;
    @(posedge i_clk);
    #1;
    {rx.crc4_sync, rx.ebit_valid, rx.fas_valid} = 3'b000;
    rx.fas_byte = ~b;
    {rx.far_ebit_one, rx.far_ebit_two} = ~b[1:0];
  endtask : pulse
endmodule : ers_far_end

//--- dv/tb_e1_rx_sync_timer_status.sv
module tb_e1_rx_sync_timer_status;
  timeunit 1ns;
  timeprecision 1ns;
  import ers_pkg::*;
  localparam int MS = 10;
  localparam logic [7:0] ID_VAL = 8'h3c; // Arbitrary value
  localparam logic [63:0] AUX = 64'ha1b2c3d4e5f60718;
  logic i_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic i_cs_n = 1'b1;
  logic i_rd_n = 1'b1;
  logic [7:0] i_page = 8'h03;
  logic [4:0] i_addr = 5'h10;
  logic [7:0] o_data;
  logic o_data_oe_n;
  logic o_force_reframe;
  ers_rx_status_t rx;
  int bad_count = 0;
  int n_tests = 0;
  int n_reframe = 0;
  logic [7:0] d;
  logic [7:0] s;

  always #50 i_clk = ~i_clk;
  always @(posedge i_clk) if (o_force_reframe === 1'b1) n_reframe++;

  ers_rx_status_bank #(.MS_CYCLES(MS), .DEVICE_ID(ID_VAL)) DUT (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_cs_n(i_cs_n), .i_rd_n(i_rd_n), .i_page(i_page),
    .i_addr(i_addr), .i_rx(rx), .i_aux(AUX), .o_data(o_data), .o_data_oe_n(o_data_oe_n),
    .o_force_reframe(o_force_reframe));
  ers_far_end FE (.i_clk(i_clk), .o_rx(rx));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic tick(input int n = 1);
    repeat (n) @(posedge i_clk);
    #1;
  endtask : tick

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : check

  task automatic tally_and_finish();
    if (bad_count == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : tally_and_finish

  task automatic wait_oe(input logic lvl);
    for (int i = 0; i < 8 && o_data_oe_n !== lvl; i++) tick();
    if (o_data_oe_n !== lvl) begin
      check("bus enable", o_data_oe_n, lvl);
      tally_and_finish();
    end
  endtask : wait_oe

  task automatic sel(input logic v);
    i_cs_n = v;
    i_rd_n = v;
  endtask : sel

  task automatic rd(input logic [4:0] a, output logic [7:0] v);
    i_addr = a;
    sel(1'b0);
    wait_oe(1'b0);
    tick();
    v = o_data;
    sel(1'b1);
    tick();
    wait_oe(1'b1);
  endtask : rd

  task automatic lose_frame();
    FE.rx.frame_loss = 1'b1;
    tick(2);
    FE.rx.frame_loss = 1'b0;
  endtask : lose_frame

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_bank();
    check("idle", {o_data_oe_n, o_data}, 9'h100);
    rd(5'h1f, d);
    check("id", d, ID_VAL);
    for (int a = 'h1b; a <= 'h1e; a++) begin
      rd(a[4:0], d);
      check("unused", d, 8'h00);
    end
    for (int a = 0; a < 8; a++) begin
      rd(5'h13 + a[4:0], d);
      check("aux", d, AUX[63-8*a -: 8]);
    end
    i_page = 8'h02;
    sel(1'b0);
    tick(6);
    check("page", o_data_oe_n, 1'b1);
    sel(1'b1);
    i_page = 8'h03;
    tick(4);
  endtask : t_bank

  task automatic t_capture();
    FE.pulse(0, 8'h64);
    FE.pulse(0, 8'h9b);
    rd(5'h11, d);
    check("fas", d, 8'h9b);
    rd(5'h11, d);
    check("fas again", d, 8'h9b);
    FE.pulse(1, 8'h02);
    rd(5'h10, d);
    check("ebits", d[4:3], 2'b10);
    FE.pulse(1, 8'h01);
    rd(5'h10, d);
    check("ebits", d[4:3], 2'b01);
  endtask : t_capture

  task automatic t_levels();
    for (int k = 0; k < 8; k++) begin
      {FE.rx.frame_loss, FE.rx.signalling_mf_loss, FE.rx.crc4_mf_loss} = k[2:0];
      rd(5'h10, d);
      check("loss", d[7:5], k[2:0]);
    end
  endtask : t_levels

  // Bit i of register a after n ms, left in s[0]
  task automatic after_ms(input int n, input logic [4:0] a, input int i);
    tick(n * MS);
    rd(a, d);
    s[0] = d[i];
  endtask : after_ms

  task automatic t_red();
    FE.rx.frame_loss = 1'b0;
    tick(2);
    FE.rx.frame_loss = 1'b1;
    after_ms(95, 5'h10, 1);
    check("red early", s[0], 1'b0);
    after_ms(10, 5'h10, 1);
    check("red", s[0], 1'b1);
    FE.rx.frame_loss = 1'b0;
    after_ms(0, 5'h10, 1);
    check("red clear", s[0], 1'b0);
  endtask : t_red

  task automatic t_hunt();
    FE.rx.crc4_mf_loss = 1'b0;
    FE.rx.maintenance_mode = 1'b1;
    lose_frame();
    tick(2 * MS);
    rd(5'h10, d);
    check("crc4 peer", {d[2], d[0]}, 2'b01);
    FE.rx.crc4_mf_loss = 1'b1;
    n_reframe = 0;
    lose_frame();
    after_ms(5, 5'h10, 2);
    check("flag early", s[0], 1'b0);
    rd(5'h12, s);
    after_ms(4, 5'h10, 2);
    check("flag", d[2], 1'b1);
    check("pulses", n_reframe, 1);
    rd(5'h12, d);
    check("short timer", d[2], !s[2]);
    s = d;
    tick(390 * MS);
    rd(5'h12, d);
    check("long timer", d[3], !s[3]);
    rd(5'h10, d);
    check("plain peer", d[0], 1'b0);
    FE.rx.auto_interworking = 1'b1;
    lose_frame();
    tick(10 * MS);
    check("no pulse", n_reframe, 1);
  endtask : t_hunt

  task automatic t_persist();
    FE.rx.nonnormal_frames = 1'b1;
    after_ms(95, 5'h12, 5);
    check("nonnormal early", s[0], 1'b0);
    after_ms(10, 5'h12, 5);
    check("nonnormal", s[0], 1'b1);
    FE.rx.nonnormal_frames = 1'b0;
    FE.rx.terminal_sync = 1'b1;
    after_ms(7, 5'h12, 4);
    check("normal early", s[0], 1'b0);
    after_ms(4, 5'h12, 4);
    check("normal over nonnormal", d[5:4], 2'b01);
    FE.rx.nonnormal_frames = 1'b1;
    after_ms(0, 5'h12, 4);
    check("normal clear", s[0], 1'b0);
    FE.rx.ais = 1'b1;
    after_ms(95, 5'h12, 0);
    check("alive early", s[0], 1'b0);
    after_ms(10, 5'h12, 0);
    check("alive", s[0], 1'b1);
    FE.rx.ais = 1'b0;
    after_ms(0, 5'h12, 0);
    check("alive clear", s[0], 1'b0);
  endtask : t_persist

  task automatic t_toggles();
    int t1a = -1;
    int t1b = -1;
    int t7a = -1;
    int t7b = -1;
    int bad6 = 0;
    logic [7:0] p;
    FE.rx.crc4_mf_loss = 1'b1;
    i_addr = 5'h12;
    sel(1'b0);
    wait_oe(1'b0);
    tick();
    p = o_data;
    for (int t = 0; t < 1100 * MS; t++) begin
      tick();
      if (o_data[1] !== p[1]) begin
        t1a = t1b;
        t1b = t;
      end
      if (o_data[7] !== p[7]) begin
        t7a = t7b;
        t7b = t;
      end
      if ((o_data[6] !== p[6]) !== (p[7] && !o_data[7])) bad6++;
      p = o_data;
    end
    check("ms gap", t1b - t1a, MS);
    check("half s gap", t7b - t7a, 500 * MS);
    check("one s toggle", bad6, 0);
    for (int t = 0; t < 2 * MS && o_data[1] === p[1]; t++) tick();
    p = o_data;
    FE.rx.crc4_mf_loss = 1'b0;
    tick(2);
    FE.pulse(2, 8'h00);
    t1a = -1;
    t1b = -1;
    for (int t = 0; t < 2 * MS; t++) begin
      tick();
      if (o_data[1] !== p[1] && t1a < 0) t1a = t;
      else if (o_data[1] !== p[1]) t1b = t;
      p = o_data;
    end
    check("sync toggle", t1a < 3, 1'b1);
    check("sync gap", t1b - t1a, MS);
    sel(1'b1);
    tick();
  endtask : t_toggles

  initial begin
    tick(3);
    i_sys_rst = 1'b0;
    tick();
    t_bank();
    t_capture();
    t_levels();
    t_red();
    t_hunt();
    t_persist();
    t_toggles();
    tally_and_finish();
  end

  initial begin
    tick(60000);
    check("watchdog", 1'b0, 1'b1);
    tally_and_finish();
  end
endmodule : tb_e1_rx_sync_timer_status
